//--- logic/tcu_params.svh
`ifndef TCU_PARAMS_SVH
`define TCU_PARAMS_SVH

// ==========================================
// Register offsets
`define TCU_A_CTRL  8'h88
`define TCU_A_MODE  8'h89
`define TCU_A_TL0   8'h8A
`define TCU_A_TL1   8'h8B
`define TCU_A_TH0   8'h8C
`define TCU_A_TH1   8'h8D
`define TCU_A_CLOCK_RATE_CONTROL 8'h8E
`define TCU_A_IE    8'hA8
`define TCU_A_IP    8'hB8
`define TCU_A_TIMER2_CONTROL 8'hC8
`define TCU_A_TIMER2_RELOAD_LOW  8'hCA
`define TCU_A_TIMER2_RELOAD_HIGH  8'hCB
`define TCU_A_TL2   8'hCC
`define TCU_A_TH2   8'hCD
`define TCU_A_MSPER 8'hD0
`define TCU_A_MSCTL 8'hD1
`define TCU_A_STS   8'hD8
`define TCU_A_MSK   8'hD9

// ==========================================
// Field positions
`define TCU_T0_BASE 0
`define TCU_T1_BASE 4
`define TCU_F_CT    2
`define TCU_F_GATE  3
`define TCU_TR0     4
`define TCU_TF0     5
`define TCU_TR1     6
`define TCU_TF1     7
`define TCU_CK_T0   3
`define TCU_CK_T1   4
`define TCU_CK_T2   5
`define TCU_T2_CT   1
`define TCU_T2_RUN  2
`define TCU_T2_GATE 3
`define TCU_T2_TF   7
`define TCU_MS_EN   0
`define TCU_S_TF0   0
`define TCU_S_TF1   1
`define TCU_S_TF2   2
`define TCU_S_MS    3

// ==========================================
// Reset values and timing
`define TCU_RST_MODE   8'h00
`define TCU_PRE_LAST   4'hB
`define TCU_PRE_FAST   2'h3
`define TCU_MS_TIME_NS 1000000
`define TCU_CLK_NS     4
`define TCU_MS_CYCLES  ((`TCU_MS_TIME_NS + `TCU_CLK_NS - 1) / `TCU_CLK_NS)
`endif

//--- logic/tcu_pkg.sv
package tcu_pkg;
   // Timer 0/1 modes in field order
   typedef enum logic [1:0] {tcu_m13, tcu_m16, tcu_mrld, tcu_msplit} tcu_mode_e;
   // Result of one count step
   typedef struct packed {
      logic [7:0] th;
      logic [7:0] tl;
      logic       ovf;
   } tcu_step_s;
   // Core register state
   typedef struct packed {
      logic [7:0] ctrl, mode, tl0, th0, tl1, th1, clock_rate_control, ie, ip;
      logic [7:0] timer2_control, timer2_reload_low, timer2_reload_high, tl2, th2, msper, msctl, sts, msk;
      logic [7:0] rdata;
      logic       irq;
      logic [3:0] pre;
   } tcu_core_s;
   // Pin sampler state
   typedef struct packed {
      logic [1:0] cur;
      logic [1:0] prv;
      logic [1:0] gate;
   } tcu_samp_s;
   // Millisecond timer state
   typedef struct packed {
      logic [17:0] cyc;
      logic [7:0]  msn;
      logic        evt;
   } tcu_ms_s;
endpackage : tcu_pkg

//--- logic/tcu_evt_if.sv
`timescale 1ns/1ns
// ==========================================
// Events and settings between core and helpers
interface tcu_evt_if;
   logic       ce;          // Clock enable
   logic [1:0] count_fall;  // Falling edge, timers 1 and 2
   logic [1:0] gate_lvl;    // Sampled gate, timers 1 and 2
   logic       ms_event;    // Millisecond period elapsed
   logic [7:0] ms_period;   // Period in milliseconds
   logic       ms_enable;   // Millisecond timer run
   modport samp (input ce, output count_fall, gate_lvl);
   modport mstm (input ce, ms_period, ms_enable, output ms_event);
   modport core (output ce, ms_period, ms_enable,
                 input count_fall, gate_lvl, ms_event);
endinterface : tcu_evt_if

//--- logic/tcu_pinsamp.sv
`timescale 1ns/1ns
`include "tcu_params.svh"
// ==========================================
// Count and gate pin sampler
module tcu_pinsamp
   import tcu_pkg::*;
(
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic sys_rst_in,
   // Pins, index 0 timer 1, index 1 timer 2
   input  wire logic [1:0] count_pin_in,
   input  wire logic [1:0] gate_pin_in,
   // Events to core
   tcu_evt_if.samp   ev
);
   tcu_samp_s r, n;  // Current and next state

   // Sample once per clock
   always_comb begin
      n = r;
      if (ev.ce) begin
         n.prv  = r.cur;
         n.cur  = count_pin_in;
         n.gate = gate_pin_in;
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) r <= '0;
      else r <= n;
   end

   // Edge from two consecutive samples
   assign ev.count_fall = r.prv & ~r.cur;
   assign ev.gate_lvl   = r.gate;

   AST_FALL_DETECT: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      ev.ce && r.cur[0] && !count_pin_in[0] |=> ev.count_fall[0])
      else $error("falling edge on count pin not detected");
endmodule : tcu_pinsamp

//--- logic/tcu_mstimer.sv
`timescale 1ns/1ns
`include "tcu_params.svh"
// ==========================================
// Millisecond software timer
module tcu_mstimer
   import tcu_pkg::*;
#(
   parameter int MS_CYCLES = `TCU_MS_CYCLES  // Clocks per millisecond
)
(
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic sys_rst_in,
   // Settings and event
   tcu_evt_if.mstm   ev
);
   tcu_ms_s r, n;  // Current and next state

   // Count clocks to a millisecond, then milliseconds to period
   always_comb begin
      n = r;
      if (ev.ce) begin
         n.evt = 1'b0;
         if (!ev.ms_enable) begin
            n.cyc = '0;  // Stopped timer restarts from zero
            n.msn = '0;
         end else if (r.cyc == 18'(MS_CYCLES - 1)) begin
            n.cyc = '0;
            if (r.msn + 8'h1 == ev.ms_period) begin
               n.msn = '0;
               n.evt = 1'b1;
            end else begin
               n.msn = r.msn + 8'h1;
            end
         end else begin
            n.cyc = r.cyc + 18'h1;
         end
      end
   end

   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) r <= '0;
      else r <= n;
   end

   assign ev.ms_event = r.evt;

   AST_MS_ONLY_ENABLED: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      r.evt |-> $past(ev.ms_enable) && r.msn == 8'h00)
      else $error("millisecond event while disabled");
endmodule : tcu_mstimer

//--- logic/tcu_top.sv
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`include "tcu_params.svh"
// ==========================================
// Timer/counter unit: timers 0, 1, 2 and ms timer
module tcu_top
   import tcu_pkg::*;
#(
   parameter int MS_CYCLES = `TCU_MS_CYCLES  // Clocks per millisecond
)
(
   // Clock, reset, enable
   input  wire logic       clock_in,
   input  wire logic       sys_rst_in,
   input  wire logic       ce_in,
   // Register port
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wr_data_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rd_data_out,
   // External count and gate pins
   input  wire logic       timer1_count_input_in,
   input  wire logic       timer1_gate_input_in,
   input  wire logic       timer2_count_input_in,
   input  wire logic       timer2_gate_input_in,
   // Interrupt
   output logic            irq_out
);

   // ==========================================
   // Helper functions

   // Prescaler tick: every 4 or every 12 clocks
   function automatic logic tcu_tick(input logic fast, input logic [3:0] pre);
      if (fast) begin
         tcu_tick = (pre[1:0] == `TCU_PRE_FAST);
      end else begin
         tcu_tick = (pre == `TCU_PRE_LAST);
      end
   endfunction : tcu_tick

   // One increment of a timer 0/1 count pair
   function automatic tcu_step_s tcu_step(input tcu_mode_e m,
                                          input logic [7:0] th,
                                          input logic [7:0] tl);
      tcu_step_s  s;
      logic [16:0] w;
      s.th  = th;
      s.tl  = tl;
      s.ovf = 1'b0;
      w     = '0;
      case (m)
         // 13 bits: high byte and low five bits
         tcu_m13: begin
            w     = {4'h0, th, tl[4:0]} + 17'h1;
            s.th  = w[12:5];
            s.tl  = {tl[7:5], w[4:0]};
            s.ovf = w[13];
         end
         // Full 16 bits
         tcu_m16: begin
            w     = {1'b0, th, tl} + 17'h1;
            s.th  = w[15:8];
            s.tl  = w[7:0];
            s.ovf = w[16];
         end
         // Low byte, reloaded from high byte
         tcu_mrld: begin
            s.ovf = (tl == 8'hFF);
            s.tl  = s.ovf ? th : tl + 8'h1;
         end
         // Split: low byte only, high byte elsewhere
         default: begin
            s.ovf = (tl == 8'hFF);
            s.tl  = tl + 8'h1;
         end
      endcase
      tcu_step = s;
   endfunction : tcu_step

   // ==========================================
   // Declarations
   tcu_core_s  r, n;        // Register state and next
   tcu_mode_e  m0, m1;      // Timer 0/1 modes
   tcu_step_s  s0, s1;      // Step results
   logic       inc0;        // Timer 0 advance
   logic       inc1;        // Timer 1 advance
   logic       inc2;        // Timer 2 advance
   logic       inc0h;       // Split high byte advance
   logic       ct1, gt1;    // Timer 1 source and gate select
   logic [7:0] set;         // Status events this cycle
   logic [7:0] clr;         // Status clears this cycle
   logic [7:0] rmux;        // Read data mux
   logic [16:0] c2;         // Timer 2 incremented

   tcu_evt_if ev ();        // Core to helpers

   // ==========================================
   // Helpers
   tcu_pinsamp u_samp (
      .clock_in     (clock_in),
      .sys_rst_in   (sys_rst_in),
      .count_pin_in ({timer2_count_input_in, timer1_count_input_in}),
      .gate_pin_in  ({timer2_gate_input_in, timer1_gate_input_in}),
      .ev           (ev.samp)
   );

   tcu_mstimer #(.MS_CYCLES(MS_CYCLES)) u_ms (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .ev         (ev.mstm)
   );

   assign ev.ce        = ce_in;
   assign ev.ms_period = r.msper;
   assign ev.ms_enable = r.msctl[`TCU_MS_EN];

   // ==========================================
   // Count enables

   // Mode fields, timer 1 upper nibble, timer 0 lower
   assign m0  = tcu_mode_e'(r.mode[`TCU_T0_BASE +: 2]);
   assign m1  = tcu_mode_e'(r.mode[`TCU_T1_BASE +: 2]);
   assign ct1 = r.mode[`TCU_T1_BASE + `TCU_F_CT];
   assign gt1 = r.mode[`TCU_T1_BASE + `TCU_F_GATE];

   // Timer 0: prescaled clock only, no pin source
   assign inc0 = r.ctrl[`TCU_TR0] && tcu_tick(r.clock_rate_control[`TCU_CK_T0], r.pre);

   // Split mode high byte uses timer 1 run bit
   assign inc0h = (m0 == tcu_msplit) && r.ctrl[`TCU_TR1]
                  && tcu_tick(r.clock_rate_control[`TCU_CK_T0], r.pre);

   // Timer 1: halted in mode 3, gated, clock or pin
   assign inc1 = (m1 != tcu_msplit) && r.ctrl[`TCU_TR1]
                 && (!gt1 || ev.gate_lvl[0])
                 && (ct1 ? ev.count_fall[0]
                         : tcu_tick(r.clock_rate_control[`TCU_CK_T1], r.pre));

   // Timer 2: same sources, 16-bit with reload
   assign inc2 = r.timer2_control[`TCU_T2_RUN]
                 && (!r.timer2_control[`TCU_T2_GATE] || ev.gate_lvl[1])
                 && (r.timer2_control[`TCU_T2_CT] ? ev.count_fall[1]
                     : tcu_tick(r.clock_rate_control[`TCU_CK_T2], r.pre));

   assign s0 = tcu_step(m0, r.th0, r.tl0);
   assign s1 = tcu_step(m1, r.th1, r.tl1);
   assign c2 = {1'b0, r.th2, r.tl2} + 17'h1;

   // ==========================================
   // Read data mux
   always_comb begin
      case (addr_in)
         // Flags mirror status bits
         `TCU_A_CTRL:  rmux = {r.sts[`TCU_S_TF1], r.ctrl[`TCU_TR1],
                               r.sts[`TCU_S_TF0], r.ctrl[`TCU_TR0], r.ctrl[3:0]};
         `TCU_A_MODE:  rmux = r.mode;
         `TCU_A_TL0:   rmux = r.tl0;
         `TCU_A_TH0:   rmux = r.th0;
         `TCU_A_TL1:   rmux = r.tl1;
         `TCU_A_TH1:   rmux = r.th1;
         `TCU_A_CLOCK_RATE_CONTROL: rmux = r.clock_rate_control;
         `TCU_A_IE:    rmux = r.ie;
         `TCU_A_IP:    rmux = r.ip;
         `TCU_A_TIMER2_CONTROL: rmux = {r.sts[`TCU_S_TF2], 3'h0, r.timer2_control[3:0]};
         `TCU_A_TIMER2_RELOAD_LOW:  rmux = r.timer2_reload_low;
         `TCU_A_TIMER2_RELOAD_HIGH:  rmux = r.timer2_reload_high;
         `TCU_A_TL2:   rmux = r.tl2;
         `TCU_A_TH2:   rmux = r.th2;
         `TCU_A_MSPER: rmux = r.msper;
         `TCU_A_MSCTL: rmux = r.msctl;
         `TCU_A_STS:   rmux = r.sts;
         `TCU_A_MSK:   rmux = r.msk;
         // Unmapped reads as zero
         default:      rmux = 8'h00;
      endcase
   end

   // ==========================================
   // Next state
   always_comb begin
      n   = r;
      set = 8'h00;
      clr = 8'h00;
      if (ce_in) begin
         // Prescaler, 0 to 11
         n.pre = (r.pre == `TCU_PRE_LAST) ? 4'h0 : r.pre + 4'h1;

         // Timer 0 low part, or whole in modes 0 to 2
         if (inc0) begin
            n.th0 = s0.th;
            n.tl0 = s0.tl;
            set[`TCU_S_TF0] = s0.ovf;
         end

         // Split mode high byte flags timer 1
         if (inc0h) begin
            n.th0 = r.th0 + 8'h1;
            set[`TCU_S_TF1] = (r.th0 == 8'hFF);
         end

         // Timer 1
         if (inc1) begin
            n.th1 = s1.th;
            n.tl1 = s1.tl;
            set[`TCU_S_TF1] = set[`TCU_S_TF1] | s1.ovf;
         end

         // Timer 2 reloads on overflow
         if (inc2) begin
            if (c2[16]) begin
               n.th2 = r.timer2_reload_high;
               n.tl2 = r.timer2_reload_low;
               set[`TCU_S_TF2] = 1'b1;
            end else begin
               n.th2 = c2[15:8];
               n.tl2 = c2[7:0];
            end
         end

         // Millisecond event
         set[`TCU_S_MS] = ev.ms_event;

         // Register writes win over counting
         if (wr_in) begin
            case (addr_in)
               `TCU_A_CTRL:  n.ctrl  = wr_data_in;
               `TCU_A_MODE:  n.mode  = wr_data_in;
               `TCU_A_TL0:   n.tl0   = wr_data_in;
               `TCU_A_TH0:   n.th0   = wr_data_in;
               `TCU_A_TL1:   n.tl1   = wr_data_in;
               `TCU_A_TH1:   n.th1   = wr_data_in;
               `TCU_A_CLOCK_RATE_CONTROL: n.clock_rate_control = wr_data_in;
               `TCU_A_IE:    n.ie    = wr_data_in;
               `TCU_A_IP:    n.ip    = wr_data_in;
               `TCU_A_TIMER2_CONTROL: n.timer2_control = {4'h0, wr_data_in[3:0]};
               `TCU_A_TIMER2_RELOAD_LOW:  n.timer2_reload_low  = wr_data_in;
               `TCU_A_TIMER2_RELOAD_HIGH:  n.timer2_reload_high  = wr_data_in;
               `TCU_A_TL2:   n.tl2   = wr_data_in;
               `TCU_A_TH2:   n.th2   = wr_data_in;
               `TCU_A_MSPER: n.msper = wr_data_in;
               `TCU_A_MSCTL: n.msctl = {7'h00, wr_data_in[`TCU_MS_EN]};
               `TCU_A_STS:   clr     = wr_data_in;
               `TCU_A_MSK:   n.msk   = {4'h0, wr_data_in[3:0]};
               // Unmapped write ignored
               default:      ;
            endcase
         end

         // Sticky status, set beats clear
         n.sts = (r.sts & ~clr) | set;

         // Read data for the next cycle only
         n.rdata = rd_in ? rmux : 8'h00;

         // Level interrupt from unmasked status
         n.irq = |(n.sts & n.msk);
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clock_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         r      <= '0;
         r.mode <= `TCU_RST_MODE;
      end else begin
         r <= n;
      end
   end

   // Outputs straight from flops
   assign rd_data_out = r.rdata;
   assign irq_out     = r.irq;

   // ==========================================
   // Checks
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (sys_rst_in);

   AST_PRESCALE_WRAP: assert property (
      ce_in && r.pre == `TCU_PRE_LAST |=> r.pre == 4'h0)
      else $error("prescaler did not wrap after twelve clocks");

   AST_T0_NO_PIN: assert property (
      ce_in && !tcu_tick(r.clock_rate_control[`TCU_CK_T0], r.pre) && !wr_in
      |=> $stable(r.tl0))
      else $error("timer 0 low byte moved without prescaler tick");

   AST_T1_PIN_COUNT: assert property (
      ce_in && !wr_in && m1 == tcu_m16 && ct1 && !gt1
      && r.ctrl[`TCU_TR1] && ev.count_fall[0] && {r.th1, r.tl1} != 16'hFFFF
      |=> {r.th1, r.tl1} == $past({r.th1, r.tl1}) + 16'h1)
      else $error("timer 1 missed a pin falling edge");

   AST_T1_GATED: assert property (
      ce_in && !wr_in && gt1 && !ev.gate_lvl[0] |=> $stable({r.th1, r.tl1}))
      else $error("timer 1 counted with gate low");

   AST_T1_HALT: assert property (
      ce_in && !wr_in && m1 == tcu_msplit |=> $stable({r.th1, r.tl1}))
      else $error("timer 1 counted in mode 3");

   AST_T0_RELOAD: assert property (
      ce_in && !wr_in && m0 == tcu_mrld && inc0 && r.tl0 == 8'hFF
      |=> r.tl0 == $past(r.th0) && r.sts[`TCU_S_TF0])
      else $error("mode 2 reload or flag missing");

   AST_T0_MODE13: assert property (
      ce_in && !wr_in && m0 == tcu_m13 && inc0
      && r.th0 == 8'hFF && r.tl0[4:0] == 5'h1F
      |=> r.th0 == 8'h00 && r.tl0[4:0] == 5'h00 && r.sts[`TCU_S_TF0])
      else $error("13-bit overflow wrong");

   AST_BYTE_WRITE: assert property (
      ce_in && wr_in && addr_in == `TCU_A_TH1 ##1 ce_in && rd_in
      && addr_in == `TCU_A_TH1 && !wr_in |=> rd_data_out == $past(wr_data_in, 2))
      else $error("high byte write not read back");

   AST_MODE_FIELDS: assert property (
      ce_in && wr_in && addr_in == `TCU_A_MODE
      |=> m1 == tcu_mode_e'($past(wr_data_in[5:4]))
       && m0 == tcu_mode_e'($past(wr_data_in[1:0])))
      else $error("mode fields in wrong nibble");

   AST_IRQ_LEVEL: assert property (
      irq_out == |(r.sts & r.msk))
      else $error("interrupt not matching unmasked status");

   // Read data returns to zero after a cycle without a read
   AST_RDATA_IDLE: assert property (
      ce_in && !rd_in |=> rd_data_out == 8'h00)
      else $error("read data not cleared after idle cycle");

   // Status bits only drop through a status write
   AST_STS_STICKY: assert property (
      ce_in && !(wr_in && addr_in == `TCU_A_STS)
      |=> (r.sts & $past(r.sts)) == $past(r.sts))
      else $error("status bit lost without clear write");

   // Timer 2 wraps onto the reload pair and flags
   AST_T2_RELOAD: assert property (
      ce_in && !wr_in && inc2 && {r.th2, r.tl2} == 16'hFFFF
      |=> {r.th2, r.tl2} == $past({r.timer2_reload_high, r.timer2_reload_low}) && r.sts[`TCU_S_TF2])
      else $error("timer 2 reload or flag missing");
endmodule : tcu_top

//--- sim/tcu_pin_model.sv
`timescale 1ns/1ns
// ==========================================
// External count and gate pin source
module tcu_pin_model (
   // Clock
   input  wire logic clock_in,
   // Pins toward the unit
   output logic      count1_out,
   output logic      gate1_out,
   output logic      count2_out,
   output logic      gate2_out
);
   // Pins idle high, gates open
   initial begin
      count1_out = 1'b1;
      gate1_out  = 1'b1;
      count2_out = 1'b1;
      gate2_out  = 1'b1;
   end
   // Falls on one count pin, each level held two clocks so every sample sees it
   task automatic pulses(input int sel, input int n);
      for (int i = 0; i < 2 * n; i++) begin
         @(posedge clock_in);
         if (sel == 1) begin
            count1_out <= i[0];
         end else begin
            count2_out <= i[0];
         end
         @(posedge clock_in);
      end
   endtask : pulses
   // Gate level for one timer
   task automatic gate(input int sel, input logic v);
      @(posedge clock_in);
      if (sel == 1) begin
         gate1_out <= v;
      end else begin
         gate2_out <= v;
      end
   endtask : gate
endmodule : tcu_pin_model

//--- sim/timer_counter_unit_test.sv
`timescale 1ns/1ns
`include "tcu_params.svh"
// ==========================================
// Self-checking bench for the timer unit
module timer_counter_unit_test;
   import tcu_pkg::*;
   localparam int MSC = 8;           // Short millisecond for sim
   logic       clock_in, sys_rst_in, ce_in, wr_in, rd_in;
   logic [7:0] addr_in, wr_data_in, rd_data_out, v, dd;
   logic       irq_out, c1, g1, c2, g2;
   logic [31:0] seed;                // Random state
   logic [7:0]  mdl [int];           // Model of storage registers
   int         fail_count, comparisons;
   // ==========================================
   // Units
   tcu_top #(.MS_CYCLES(MSC)) uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
      .ce_in(ce_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
      .rd_in(rd_in), .rd_data_out(rd_data_out), .timer1_count_input_in(c1),
      .timer1_gate_input_in(g1), .timer2_count_input_in(c2),
      .timer2_gate_input_in(g2), .irq_out(irq_out));
   tcu_pin_model pins (.clock_in(clock_in), .count1_out(c1), .gate1_out(g1),
      .count2_out(c2), .gate2_out(g2));
   // ==========================================
   // Clock
   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   // Next random value
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : xs
   // Compare and count
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One write cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_in    <= a;
      wr_data_in <= d;
      wr_in      <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask : wr
   // One read cycle, data taken in the following cycle
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      @(negedge clock_in);
      d = rd_data_out;
   endtask : rd
   // Count change over n clocks, or over k pin falls
   task automatic span(input logic [7:0] a, input int n, input int sel, input int k);
      logic [7:0] v0;
      rd(a, v0);
      if (k > 0) begin
         pins.pulses(sel, k);
         repeat (4) @(posedge clock_in);
      end else begin
         repeat (n - 2) @(posedge clock_in);
      end
      rd(a, v);
      dd = v - v0;
   endtask : span
   // Verdict
   task automatic final_report();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : final_report
   // Watchdog
   initial begin
      #200000;
      fail_count++;
      final_report();
   end
   // ==========================================
   // Main sequence
   initial begin
      seed = 32'hBCFF08C2;
      fail_count = 0;
      comparisons = 0;
      {wr_in, rd_in, addr_in, wr_data_in} = '0;
      ce_in = 1'b1;
      sys_rst_in = 1'b1;
      repeat (20) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      rd(`TCU_A_MODE, v);
      chk("mode reset", v, 8'h00);
      rd(8'h80, v);
      chk("unmapped", v, 8'h00);
      // Storage registers with random data
      for (int i = 0; i < 4; i++) begin
         automatic logic [7:0] a = (i == 0) ? `TCU_A_IE : (i == 1) ? `TCU_A_IP :
                                   (i == 2) ? `TCU_A_TIMER2_RELOAD_LOW : `TCU_A_TIMER2_RELOAD_HIGH;
         mdl[a] = xs();
         wr(a, mdl[a]);
         rd(a, v);
         chk("storage", v, mdl[a]);
      end
      // Write with clock enable low is ignored
      @(posedge clock_in);
      ce_in <= 1'b0;
      wr(`TCU_A_IE, ~mdl[`TCU_A_IE]);
      ce_in <= 1'b1;
      rd(`TCU_A_IE, v);
      chk("ce low", v, mdl[`TCU_A_IE]);
      // Timer 0, 16-bit, pin select ignored, slow then fast rate
      wr(`TCU_A_MODE, 8'h05);
      wr(`TCU_A_CLOCK_RATE_CONTROL, 8'h00);
      wr(`TCU_A_CTRL, 8'h10);
      span(`TCU_A_TL0, 48, 0, 0);
      chk("t0 slow", dd, 8'h04);
      wr(`TCU_A_CLOCK_RATE_CONTROL, 8'h08);
      span(`TCU_A_TL0, 48, 0, 0);
      chk("t0 fast", dd, 8'h0C);
      // Timer 0 reload mode, flag and interrupt
      wr(`TCU_A_CTRL, 8'h00);
      wr(`TCU_A_MSK, 8'h00);
      wr(`TCU_A_STS, 8'h0F);
      wr(`TCU_A_MODE, 8'h02);
      wr(`TCU_A_TH0, 8'hF0);
      wr(`TCU_A_TL0, 8'hFE);
      wr(`TCU_A_CTRL, 8'h10);
      repeat (40) @(posedge clock_in);
      wr(`TCU_A_CTRL, 8'h00);
      rd(`TCU_A_TL0, v);
      chk("reload", {4'h0, v[7:4]}, 8'h0F);
      rd(`TCU_A_STS, v);
      chk("flag", v, 8'h01);
      chk("irq masked", {7'h0, irq_out}, 8'h00);
      wr(`TCU_A_MSK, 8'h01);
      repeat (2) @(posedge clock_in);
      chk("irq set", {7'h0, irq_out}, 8'h01);
      wr(`TCU_A_STS, 8'h01);
      repeat (2) @(posedge clock_in);
      chk("irq clear", {7'h0, irq_out}, 8'h00);
      // Timer 1 counts pin falls, then gated
      wr(`TCU_A_MODE, 8'h50);
      wr(`TCU_A_CTRL, 8'h40);
      span(`TCU_A_TL1, 0, 1, 5);
      chk("t1 pin", dd, 8'h05);
      wr(`TCU_A_MODE, 8'hD0);
      pins.gate(1, 1'b0);
      span(`TCU_A_TL1, 0, 1, 3);
      chk("t1 gate low", dd, 8'h00);
      pins.gate(1, 1'b1);
      span(`TCU_A_TL1, 0, 1, 3);
      chk("t1 gate high", dd, 8'h03);
      // Timer 1 halts in split mode
      wr(`TCU_A_MODE, 8'h30);
      span(`TCU_A_TL1, 48, 0, 0);
      chk("t1 halt", dd, 8'h00);
      // Timer 2 counts pin falls
      wr(`TCU_A_TIMER2_CONTROL, 8'h06);
      span(`TCU_A_TL2, 0, 2, 4);
      chk("t2 pin", dd, 8'h04);
      wr(`TCU_A_TIMER2_CONTROL, 8'h00);
      // Millisecond timer with two short milliseconds
      wr(`TCU_A_STS, 8'h0F);
      wr(`TCU_A_MSPER, 8'h02);
      wr(`TCU_A_MSCTL, 8'h01);
      repeat (6) @(posedge clock_in);
      rd(`TCU_A_STS, v);
      chk("ms early", v, 8'h00);
      repeat (12) @(posedge clock_in);
      rd(`TCU_A_STS, v);
      chk("ms event", v, 8'h08);
      wr(`TCU_A_MSCTL, 8'h00);
      // Timer 0 in 13-bit mode wraps from the top of its range
      wr(`TCU_A_CTRL, 8'h00);
      wr(`TCU_A_MODE, 8'h00);
      wr(`TCU_A_TH0, 8'hFF);
      wr(`TCU_A_TL0, 8'hFE);
      wr(`TCU_A_STS, 8'h0F);
      wr(`TCU_A_CTRL, 8'h10);
      repeat (40) @(posedge clock_in);
      wr(`TCU_A_CTRL, 8'h00);
      rd(`TCU_A_TH0, v);
      chk("m13 high", v, 8'h00);
      rd(`TCU_A_TL0, v);
      chk("m13 top", {5'h00, v[7:5]}, 8'h07);
      rd(`TCU_A_STS, v);
      chk("m13 flag", v, 8'h01);
      chk("irq m13", {7'h0, irq_out}, 8'h01);
      final_report();
   end
endmodule : timer_counter_unit_test
